//--- inc/sstp_pkg.sv
// Shared constants and types of the synchronous serial target programmer
package sstp_pkg;

    // Clock rate and nominal link timing
    localparam int unsigned CLK_KHZ = 50000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RESET_LOW_MS = 20;
    localparam int unsigned RECOVERY_MS = 500;
    localparam int unsigned BUSY_TIMEOUT_MS = 100;
    localparam int unsigned SCLK_PERIOD_NS = 160;

    // Derived cycle counts; the three timeouts are whole milliseconds and the clock half divides evenly, so no rounding applies
    localparam logic [31:0] RESET_LOW_CYC = 32'(RESET_LOW_MS * CLK_KHZ);
    localparam logic [31:0] RECOVERY_CYC = 32'(RECOVERY_MS * CLK_KHZ);
    localparam logic [31:0] BUSY_TIMEOUT_CYC = 32'(BUSY_TIMEOUT_MS * CLK_KHZ);
    localparam int unsigned SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // Byte framing
    localparam int unsigned BITS_PER_BYTE = 8;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // Error codes reported on abort
    localparam logic [7:0] ERR_BUSY_AT_START = 8'h28;
    localparam logic [7:0] ERR_BUSY_NO_REACT = 8'h29;
    localparam logic [7:0] ERR_BUSY_TIMEOUT = 8'h09;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_RECOVER,
        ST_READY,
        ST_BIT_LO,
        ST_BIT_HI,
        ST_WAIT_LOW
    } sstp_state_t;

    typedef struct packed {
        sstp_state_t st;
        logic [31:0] cnt;
        logic [2:0] bit_idx;
        logic [7:0] tx;
        logic [7:0] rx;
        logic sclk;
        logic din;
        logic rst_out_n;
        logic busy_s1;
        logic busy_s2;
        logic sdo_s1;
        logic sdo_s2;
        logic rsp_v;
        logic [7:0] rsp_d;
        logic err_v;
        logic [7:0] err_c;
    } sstp_regs_t;

endpackage : sstp_pkg

//--- core/sstp_programmer.sv
// Session and byte sequencer of the synchronous serial target programmer
`timescale 1ns/1ns
module sstp_programmer
    import sstp_pkg::*;
#(
    parameter logic [31:0] RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter logic [31:0] RECOVERY_CYCLES = RECOVERY_CYC,
    parameter logic [31:0] TIMEOUT_CYCLES = BUSY_TIMEOUT_CYC,
    parameter int unsigned HALF_CYCLES = SCLK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic session_start,
    input wire logic session_stop,
    input wire logic [31:0] cfg_reset_low_cyc,
    input wire logic [31:0] cfg_recovery_cyc,
    input wire logic [31:0] cfg_timeout_cyc,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic err_valid,
    output logic [7:0] err_code,
    output logic session_active,
    output logic tgt_rst_n_o,
    output logic tgt_sclk_o,
    output logic tgt_din_o,
    input wire logic tgt_busy_i,
    input wire logic tgt_dout_i,
    output logic tgt_dout_o,
    output logic tgt_dout_oe
);

    // Sync latency is two cycles, so the low half must outlast it
    if (HALF_CYCLES < 3 || RESET_LOW_CYCLES == 32'h0 || RECOVERY_CYCLES == 32'h0
        || TIMEOUT_CYCLES == 32'h0) begin : g_bad_param
        $error("sstp_programmer: unsupported parameter value");
    end

    localparam logic [31:0] HALF = 32'(HALF_CYCLES);
    localparam sstp_regs_t RST_VAL = '{st: ST_IDLE, sclk: 1'b1, din: 1'b1, rst_out_n: 1'b1,
                                       busy_s1: 1'b1, busy_s2: 1'b1, default: '0};

    sstp_regs_t r_ff;
    sstp_regs_t nxt_r;
    logic [31:0] eff_low;
    logic [31:0] eff_rec;
    logic [31:0] eff_to;

    // Zero in a config input falls back to the built-in default
    assign eff_low = (cfg_reset_low_cyc != 32'h0) ? cfg_reset_low_cyc : RESET_LOW_CYCLES;
    assign eff_rec = (cfg_recovery_cyc != 32'h0) ? cfg_recovery_cyc : RECOVERY_CYCLES;
    assign eff_to = (cfg_timeout_cyc != 32'h0) ? cfg_timeout_cyc : TIMEOUT_CYCLES;

    // Next-state logic of the whole sequencer
    always_comb begin
        nxt_r = r_ff;
        nxt_r.busy_s1 = tgt_busy_i;
        nxt_r.busy_s2 = r_ff.busy_s1;
        nxt_r.sdo_s1 = tgt_dout_i;
        nxt_r.sdo_s2 = r_ff.sdo_s1;
        nxt_r.rsp_v = 1'b0;
        nxt_r.err_v = 1'b0;
        unique case (r_ff.st)
            ST_IDLE: begin
                nxt_r.sclk = 1'b1;
                nxt_r.din = 1'b1;
                nxt_r.rst_out_n = 1'b1;
                if (session_start) begin
                    nxt_r.st = ST_RST_LOW;
                    nxt_r.rst_out_n = 1'b0;
                    nxt_r.cnt = eff_low;
                end
            end
            ST_RST_LOW: begin
                if (r_ff.cnt > 32'h1) begin
                    nxt_r.cnt = r_ff.cnt - 32'h1;
                end else begin
                    nxt_r.rst_out_n = 1'b1;
                    nxt_r.st = ST_RECOVER;
                    nxt_r.cnt = eff_rec;
                end
            end
            ST_RECOVER: begin
                // Clock stays high all through recovery
                if (r_ff.cnt > 32'h1) begin
                    nxt_r.cnt = r_ff.cnt - 32'h1;
                end else if (r_ff.busy_s2) begin
                    // Pull-up makes a missing target look busy, so it aborts here
                    nxt_r.err_v = 1'b1;
                    nxt_r.err_c = ERR_BUSY_AT_START;
                    nxt_r.st = ST_IDLE;
                end else begin
                    nxt_r.st = ST_READY;
                end
            end
            ST_READY: begin
                if (session_stop) begin
                    nxt_r.st = ST_IDLE;
                end else if (cmd_valid) begin
                    nxt_r.tx = cmd_data;
                    nxt_r.bit_idx = 3'h0;
                    nxt_r.sclk = 1'b0;
                    nxt_r.din = cmd_data[0];
                    nxt_r.cnt = HALF;
                    nxt_r.st = ST_BIT_LO;
                end
            end
            ST_BIT_LO: begin
                if (r_ff.cnt > 32'h1) begin
                    nxt_r.cnt = r_ff.cnt - 32'h1;
                end else begin
                    nxt_r.sclk = 1'b1;
                    nxt_r.rx = {r_ff.sdo_s2, r_ff.rx[7:1]};
                    nxt_r.cnt = HALF;
                    nxt_r.st = ST_BIT_HI;
                end
            end
            ST_BIT_HI: begin
                if (r_ff.cnt > 32'h1) begin
                    nxt_r.cnt = r_ff.cnt - 32'h1;
                end else if (r_ff.bit_idx == 3'h0 && !r_ff.busy_s2) begin
                    nxt_r.err_v = 1'b1;
                    nxt_r.err_c = ERR_BUSY_NO_REACT;
                    nxt_r.st = ST_IDLE;
                end else if (r_ff.bit_idx == 3'(BITS_PER_BYTE - 1)) begin
                    nxt_r.din = 1'b1;
                    nxt_r.cnt = eff_to;
                    nxt_r.st = ST_WAIT_LOW;
                end else begin
                    // Seven more pulses after the busy check
                    nxt_r.bit_idx = r_ff.bit_idx + 3'h1;
                    nxt_r.tx = {1'b1, r_ff.tx[7:1]};
                    nxt_r.din = r_ff.tx[1];
                    nxt_r.sclk = 1'b0;
                    nxt_r.cnt = HALF;
                    nxt_r.st = ST_BIT_LO;
                end
            end
            ST_WAIT_LOW: begin
                if (!r_ff.busy_s2) begin
                    nxt_r.rsp_v = 1'b1;
                    nxt_r.rsp_d = r_ff.rx;
                    nxt_r.st = ST_READY;
                end else if (r_ff.cnt > 32'h1) begin
                    nxt_r.cnt = r_ff.cnt - 32'h1;
                end else begin
                    nxt_r.err_v = 1'b1;
                    nxt_r.err_c = ERR_BUSY_TIMEOUT;
                    nxt_r.st = ST_IDLE;
                end
            end
        endcase
    end

    // State register; clock enable freezes everything except the synchronous reset, which loads RST_VAL whatever ce is
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_ff <= RST_VAL;
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    // Outputs; the target output line is only observed, never driven
    assign cmd_ready = ce && (r_ff.st == ST_READY) && !session_stop;
    assign rsp_valid = r_ff.rsp_v;
    assign rsp_data = r_ff.rsp_d;
    assign err_valid = r_ff.err_v;
    assign err_code = r_ff.err_c;
    assign session_active = (r_ff.st != ST_IDLE);
    assign tgt_rst_n_o = r_ff.rst_out_n;
    assign tgt_sclk_o = r_ff.sclk;
    assign tgt_din_o = r_ff.din;
    assign tgt_dout_o = 1'b0;
    assign tgt_dout_oe = 1'b0;

    // Helper counters for the checks below
    logic [31:0] chk_low_ff;
    logic [3:0] chk_falls_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_low_ff <= 32'h0;
            chk_falls_ff <= 4'h0;
        end else if (ce) begin
            chk_low_ff <= nxt_r.rst_out_n ? 32'h0 : chk_low_ff + 32'h1;
            // The accepting edge already launches the first fall, so count it there
            if (r_ff.st == ST_READY || r_ff.st == ST_IDLE) begin
                chk_falls_ff <= (r_ff.sclk && !nxt_r.sclk) ? 4'h1 : 4'h0;
            end else if (r_ff.sclk && !nxt_r.sclk) begin
                chk_falls_ff <= chk_falls_ff + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_RST_LEN: assert property ($rose(tgt_rst_n_o) |-> chk_low_ff == 32'h0
        && $past(chk_low_ff) == eff_low) else $error("reset low time wrong");
    AST_REC_QUIET: assert property ((r_ff.st == ST_RECOVER || r_ff.st == ST_RST_LOW)
        |-> tgt_sclk_o) else $error("clock moved during reset or recovery");
    AST_ERR40: assert property (err_valid && err_code == ERR_BUSY_AT_START
        |-> $past(r_ff.busy_s2) && $past(r_ff.st) == ST_RECOVER && chk_falls_ff == 4'h0)
        else $error("busy-at-start abort without cause");
    AST_ERR41: assert property (err_valid && err_code == ERR_BUSY_NO_REACT
        |-> !$past(r_ff.busy_s2) && chk_falls_ff == 4'h1) else $error("bad no-react abort");
    AST_BYTE_BITS: assert property (rsp_valid |-> chk_falls_ff == 4'(BITS_PER_BYTE))
        else $error("byte did not carry eight clocks");
    AST_DIN_STABLE: assert property ($rose(tgt_sclk_o) |-> $stable(tgt_din_o))
        else $error("data changed on rising clock");
    AST_PULSE_SHAPE: assert property ($fell(tgt_sclk_o) |-> !tgt_sclk_o [*3])
        else $error("clock low phase too short");
    AST_TIMEOUT: assert property (err_valid && err_code == ERR_BUSY_TIMEOUT
        |-> $past(r_ff.st) == ST_WAIT_LOW && $past(r_ff.busy_s2)) else $error("bad timeout");
    AST_NEXT_BYTE: assert property (rsp_valid |-> !$past(r_ff.busy_s2)
        && r_ff.st == ST_READY) else $error("byte ended with busy high");

    COV_BYTE: cover property (rsp_valid);
    COV_ERR40: cover property (err_valid && err_code == ERR_BUSY_AT_START);
    COV_ERR41: cover property (err_valid && err_code == ERR_BUSY_NO_REACT);
    COV_TIMEOUT: cover property (err_valid && err_code == ERR_BUSY_TIMEOUT);

endmodule : sstp_programmer

//--- testbench/sstp_target_model.sv
// Behavioural target bootloader on the clocked serial link
`timescale 1ns/1ns
module sstp_target_model (
    input wire logic clk,
    input wire logic rst_n_t,
    input wire logic sclk,
    input wire logic din,
    input wire logic [1:0] mode,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] rel_dly,
    output logic busy_oe,
    output logic busy_val,
    output logic dout,
    output logic [7:0] rx_byte
);
    int n = 0;

    // Mode 0 normal, 1 busy never rises, 2 busy never falls, 3 busy released
    assign busy_oe = (mode != 2'h3);

    // Target in reset forgets any half byte and drops busy
    always @(negedge rst_n_t) begin
        n = 0;
        busy_val = 1'b0;
    end

    // Bit loop follows the programmer's clock, not our own
    initial begin
        busy_val = 1'b0;
        dout = 1'b1;
        rx_byte = 8'h00;
        forever begin
            @(negedge sclk);
            // Move off the clock edge that launched the fall, so no race with sampling
            @(negedge clk);
            dout = tx_byte[n];
            @(posedge sclk);
            rx_byte[n] = din;
            @(negedge clk);
            if (n == 0 && mode != 2'h1) busy_val = 1'b1;
            n = n + 1;
            if (n == 8) begin
                n = 0;
                // Line shows stale-inverse data between bytes
                dout = ~dout;
                if (mode != 2'h2) begin
                    repeat (rel_dly) @(posedge clk);
                    @(negedge clk);
                    busy_val = 1'b0;
                end
            end
        end
    end
endmodule : sstp_target_model

//--- testbench/testbench.sv
// Self-checking bench of the target programmer sequencer
`timescale 1ns/1ns
module testbench;
    import sstp_pkg::*;
    // Short counts keep the run small; expectations derive from these
    localparam logic [31:0] RL = 32'h14;
    localparam logic [31:0] RC = 32'h32;
    localparam logic [31:0] TMO = 32'hC8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic [31:0] cfg_rl = 32'h0;
    logic [31:0] cfg_rc = 32'h0;
    logic [31:0] cfg_to = 32'h0;
    logic dout_oe;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rel_dly = 8'h02;
    logic cmd_ready, rsp_valid, err_valid, active, rst_t_n, sclk, din;
    logic busy_oe, busy_val, dout, busy_w;
    logic [7:0] rsp_data, err_code, rx_byte;
    int err_total = 0;
    int checks_done = 0;
    int falls = 0;
    int lo_cnt = 0;
    int k = 0;

    // 50 MHz clock
    always #10 clk = ~clk;
    // Pull-up holds busy high when the target lets go
    assign busy_w = busy_oe ? busy_val : 1'b1;
    // Link monitors: clock pulses and reset-low cycles
    always @(negedge sclk) falls++;
    always @(posedge clk) if (!rst_t_n) lo_cnt++;

    sstp_programmer #(.RESET_LOW_CYCLES(RL), .RECOVERY_CYCLES(RC), .TIMEOUT_CYCLES(TMO),
        .HALF_CYCLES(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .session_start(start), .session_stop(stop),
        .cfg_reset_low_cyc(cfg_rl), .cfg_recovery_cyc(cfg_rc), .cfg_timeout_cyc(cfg_to),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .err_valid(err_valid),
        .err_code(err_code), .session_active(active), .tgt_rst_n_o(rst_t_n),
        .tgt_sclk_o(sclk), .tgt_din_o(din), .tgt_busy_i(busy_w), .tgt_dout_i(dout),
        .tgt_dout_o(), .tgt_dout_oe(dout_oe));

    sstp_target_model i_tgt (
        .clk(clk), .rst_n_t(rst_t_n), .sclk(sclk), .din(din), .mode(mode),
        .tx_byte(tx_byte), .rel_dly(rel_dly), .busy_oe(busy_oe), .busy_val(busy_val),
        .dout(dout), .rx_byte(rx_byte));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // Bounded wait for ready, response or abort, sampled after the edge
    task automatic wait_done();
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((cmd_ready | rsp_valid | err_valid) !== 1'b1 && k < 2000);
        // A wait that runs out is a failure by itself
        if (k >= 2000) begin
            err_total++;
            stop_test();
        end
    endtask : wait_done

    task automatic session(input logic [31:0] rl, input logic [31:0] rc);
        @(negedge clk);
        cfg_rl = rl;
        cfg_rc = rc;
        start = 1'b1;
        falls = 0;
        lo_cnt = 0;
        @(negedge clk);
        start = 1'b0;
        wait_done();
    endtask : session

    // Request held from one falling edge across the accepting rising edge
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] tx);
        @(negedge clk);
        cmd_data = cmd;
        tx_byte = tx;
        cmd_valid = 1'b1;
        falls = 0;
        @(negedge clk);
        cmd_valid = 1'b0;
        wait_done();
    endtask : xfer

    task automatic s_timing();
        session(32'h0, 32'h0);
        check("low_len", lo_cnt, RL);
        check("ready_at", k, RL + RC);
        check("quiet", falls, 0);
        @(negedge clk);
        stop = 1'b1;
        @(negedge clk);
        stop = 1'b0;
        session(32'h1E, 32'h3C);
        check("cfg_low_len", lo_cnt, 32'h1E);
        check("cfg_ready_at", k, 32'h5A);
    endtask : s_timing

    // Back-to-back full-duplex bytes, prompt then slow busy release
    task automatic s_bytes();
        logic [7:0] cs [2] = '{8'hA5, 8'h01};
        logic [7:0] ts [2] = '{8'h3C, 8'h80};
        logic [7:0] ds [2] = '{8'h02, 8'h28};
        for (int i = 0; i < 2; i++) begin
            rel_dly = ds[i];
            xfer(cs[i], ts[i]);
            check("rsp", rsp_valid, 1'b1);
            check("rx", rsp_data, ts[i]);
            check("din_bits", rx_byte, cs[i]);
            check("clocks", falls, 8);
            check("sclk_high", sclk, 1'b1);
            // 60 cycles to the last rising clock, release ds[i] later, busy seen low two sync edges after that, then the answer
            check("waits", k, 63 + ds[i]);
        end
    endtask : s_bytes

    task automatic s_faults();
        mode = 2'h1;
        xfer(8'h55, 8'h00);
        check("err41", err_code, ERR_BUSY_NO_REACT);
        repeat (20) @(posedge clk);
        check("one_clk", falls, 1);
        mode = 2'h3;
        session(32'h0, 32'h0);
        check("err40", err_code, ERR_BUSY_AT_START);
        check("err40_v", err_valid, 1'b1);
        check("no_clk", falls, 0);
        check("active_abort", active, 1'b0);
        mode = 2'h2;
        session(32'h0, 32'h0);
        check("ready2", cmd_ready, 1'b1);
        xfer(8'h5A, 8'hC3);
        check("err_tmo", err_code, ERR_BUSY_TIMEOUT);
        check("tmo_len", k, 64 + TMO);
        // Same stall with the run-time limit in place of the default
        @(negedge clk);
        cfg_to = 32'h64;
        session(32'h0, 32'h0);
        xfer(8'h5A, 8'hC3);
        check("cfg_err_tmo", err_code, ERR_BUSY_TIMEOUT);
        check("cfg_tmo_len", k, 32'hA4);
    endtask : s_faults

    task automatic stop_test();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // Reset held two cycles, then idle outputs and the scenarios
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        check("rst_out", rst_t_n, 1'b1);
        check("sclk_idle", sclk, 1'b1);
        check("active", active, 1'b0);
        check("dout_oe", dout_oe, 1'b0);
        s_timing();
        s_bytes();
        s_faults();
        stop_test();
    end

    // Whole run is about a thousand cycles; this cuts a hang short
    initial begin
        #1000000;
        err_total++;
        stop_test();
    end
endmodule : testbench
